// ===== logic/status_led_pkg.sv
// Shared constants for the bridge input status indicator logic
package status_led_pkg;
    // Slave state machine codes
    typedef enum logic [2:0] {
        SLV_INIT = 3'h1,
        SLV_PREOP = 3'h2,
        SLV_BOOT = 3'h3,
        SLV_SAFEOP = 3'h4,
        SLV_OP = 3'h0
    } slave_state_t;

    // Clock rate and pattern timing
    localparam int CLK_HZ = 25000000;
    localparam int FLASH_MS = 200;
    localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    localparam int SINGLE_ON_MS = 200;
    localparam int SINGLE_ON_CYC = (CLK_HZ / 1000) * SINGLE_ON_MS;
    localparam int SINGLE_PERIOD_MS = 1200;
    localparam int SINGLE_PERIOD_CYC = (CLK_HZ / 1000) * SINGLE_PERIOD_MS;
    localparam int FLICKER_MS = 50;
    localparam int FLICKER_CYC = (CLK_HZ / 1000) * FLICKER_MS;

    // Reset values
    localparam logic LED_RESET = 1'b0;
    localparam logic SAFE_RESET = 1'b1;
    localparam logic QUAL_RESET = 1'b0;
endpackage

// ===== logic/pattern_divider.sv
// Free-running divider producing one blink pattern
`timescale 1ns/100ps
`default_nettype none
module pattern_divider #(
    parameter int PERIOD_CYC = 10,
    parameter int ON_CYC = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Pattern output
    output logic pattern
);
    localparam int CW = $clog2(PERIOD_CYC);

    // A lit phase of zero or of the whole period would freeze the lamp
    if (ON_CYC < 1 || ON_CYC >= PERIOD_CYC) begin : checkOnTime
        $error("pattern_divider: on time must be within the period");
    end

    logic [CW-1:0] count_ff;
    logic pattern_ff;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            count_ff <= '0;
        end else if (count_ff == CW'(PERIOD_CYC - 1)) begin
            count_ff <= '0;
        end else begin
            count_ff <= count_ff + CW'(1);
        end
    end

    // Registered so the pattern edge never glitches the LED
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pattern_ff <= 1'b0;
        end else begin
            pattern_ff <= (count_ff < CW'(ON_CYC));
        end
    end

    assign pattern = pattern_ff;
endmodule
`default_nettype wire

// ===== logic/bridge_input_status_leds.sv
// Front-panel status indicator logic for a bridge measurement input
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Run LED: off INIT, flash PREOP, single flash SAFEOP, on OP, flicker BOOTSTRAP.
// - In SAFEOP outputs stay safe; data exchange only enabled in OP.
// - Stability LED lit exactly while measured value is stable.
// - Measuring LED lit only while measuring with valid process data.
// - Measuring LED dark during self-calibration, self-test or filter initialisation.
// - Self-calibration LED lit during calibration; process data invalid then.
// - Self-test LED lit during self-test; process data invalid then.
// - Differential error LED lit while channel 1 is out of range.
// - Reference error LED lit while channel 2 is out of range.
module bridge_input_status_leds #(
    parameter int FLASH_CYC = status_led_pkg::FLASH_CYC,
    parameter int SINGLE_ON_CYC = status_led_pkg::SINGLE_ON_CYC,
    parameter int SINGLE_PERIOD_CYC = status_led_pkg::SINGLE_PERIOD_CYC,
    parameter int FLICKER_CYC = status_led_pkg::FLICKER_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Slave state
    input wire logic [2:0] slaveState,
    // Measurement core condition
    input wire logic valueStable,
    input wire logic measRunning,
    input wire logic selfCalActive,
    input wire logic selfTestActive,
    input wire logic filterInit,
    input wire logic diffOutOfRange,
    input wire logic refOutOfRange,
    // Indicators
    output logic run_led,
    output logic stable_led,
    output logic measuring_led,
    output logic self_cal_led,
    output logic self_test_led,
    output logic diff_range_error_led,
    output logic ref_range_error_led,
    // Data path qualifiers
    output logic outputsSafe,
    output logic dataExchangeEn,
    output logic processDataValid
);
    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // Flicker must stay clearly faster than flashing or the operator cannot tell them apart
    if (FLICKER_CYC < 2) begin : checkFlickerMin
        $error("bridge_input_status_leds: flicker phase must last at least two cycles");
    end
    if (FLICKER_CYC >= FLASH_CYC) begin : checkFlickerOrder
        $error("bridge_input_status_leds: flicker must be faster than flashing");
    end
    // A single flash is only recognisable if its period is longer than a flash period
    if (SINGLE_PERIOD_CYC <= 2 * FLASH_CYC) begin : checkSingleOrder
        $error("bridge_input_status_leds: single flash period must exceed the flash period");
    end
    if (SINGLE_ON_CYC < 1 || SINGLE_ON_CYC >= SINGLE_PERIOD_CYC) begin : checkSingleOn
        $error("bridge_input_status_leds: single flash lit time must lie inside its period");
    end

    // ----------------------------------------------------------------
    // Pattern generators
    // ----------------------------------------------------------------
    logic flashPat;
    logic singlePat;
    logic flickerPat;

    // Dividers never restart on a state change, so a new pattern may begin mid-phase
    // free-running dividers
    pattern_divider #(.PERIOD_CYC(2 * FLASH_CYC), .ON_CYC(FLASH_CYC)) flashDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .pattern(flashPat)
    );
    pattern_divider #(.PERIOD_CYC(SINGLE_PERIOD_CYC), .ON_CYC(SINGLE_ON_CYC)) singleDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .pattern(singlePat)
    );
    pattern_divider #(.PERIOD_CYC(2 * FLICKER_CYC), .ON_CYC(FLICKER_CYC)) flickerDiv (
        .core_clk(core_clk),
        .resetn(resetn),
        .pattern(flickerPat)
    );

    // ----------------------------------------------------------------
    // Run indicator and state qualifiers
    // ----------------------------------------------------------------
    status_led_pkg::slave_state_t curState;
    logic run_led_ff;
    logic outputsSafe_ff;
    logic dataExchangeEn_ff;

    // Codes outside the enum reach the default branch and show as INIT
    assign curState = status_led_pkg::slave_state_t'(slaveState);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            run_led_ff <= status_led_pkg::LED_RESET;
        end else begin
            case (curState)
                status_led_pkg::SLV_INIT: begin
                    run_led_ff <= 1'b0;
                end
                status_led_pkg::SLV_PREOP: begin
                    run_led_ff <= flashPat;
                end
                status_led_pkg::SLV_SAFEOP: begin
                    run_led_ff <= singlePat;
                end
                status_led_pkg::SLV_OP: begin
                    run_led_ff <= 1'b1;
                end
                status_led_pkg::SLV_BOOT: begin
                    run_led_ff <= flickerPat;
                end
                default: begin
                    // Unknown code is shown as INIT
                    run_led_ff <= 1'b0;
                end
            endcase
        end
    end

    // Reset keeps the outputs safe until a state has been sampled
    // safe outputs outside OP
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            outputsSafe_ff <= status_led_pkg::SAFE_RESET;
            dataExchangeEn_ff <= status_led_pkg::QUAL_RESET;
        end else begin
            outputsSafe_ff <= (curState != status_led_pkg::SLV_OP);
            dataExchangeEn_ff <= (curState == status_led_pkg::SLV_OP);
        end
    end

    // ----------------------------------------------------------------
    // Measurement indicators
    // ----------------------------------------------------------------
    logic stable_ff;
    logic measuring_ff;
    logic selfCal_ff;
    logic selfTest_ff;
    logic dataValid_ff;
    logic dataBlocked;

    // Filter start-up counts as blocked because early samples are not yet settled
    // calibration, test and filter start block measuring
    assign dataBlocked = selfCalActive | selfTestActive | filterInit;

    // Stability judgement belongs to the core; the lamp only mirrors it
    // stability follows judgement
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stable_ff <= status_led_pkg::LED_RESET;
        end else begin
            stable_ff <= valueStable;
        end
    end

    // Lamp and validity share one term so they can never disagree
    // measuring only with valid data
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            measuring_ff <= status_led_pkg::LED_RESET;
            dataValid_ff <= status_led_pkg::QUAL_RESET;
        end else begin
            measuring_ff <= measRunning & ~dataBlocked;
            dataValid_ff <= measRunning & ~dataBlocked;
        end
    end

    // Validity is withdrawn through the measuring gate, not here
    // calibration and test lamps
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            selfCal_ff <= status_led_pkg::LED_RESET;
            selfTest_ff <= status_led_pkg::LED_RESET;
        end else begin
            selfCal_ff <= selfCalActive;
            selfTest_ff <= selfTestActive;
        end
    end

    // ----------------------------------------------------------------
    // Range error indicators
    // ----------------------------------------------------------------
    logic diffErr_ff;
    logic refErr_ff;

    // No latching: a lamp goes dark as soon as its channel is back in range
    // channel range errors
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            diffErr_ff <= status_led_pkg::LED_RESET;
            refErr_ff <= status_led_pkg::LED_RESET;
        end else begin
            diffErr_ff <= diffOutOfRange;
            refErr_ff <= refOutOfRange;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every lamp comes straight from a flip-flop so no decode glitch reaches it
    assign run_led = run_led_ff;
    assign stable_led = stable_ff;
    assign measuring_led = measuring_ff;
    assign self_cal_led = selfCal_ff;
    assign self_test_led = selfTest_ff;
    assign diff_range_error_led = diffErr_ff;
    assign ref_range_error_led = refErr_ff;
    assign outputsSafe = outputsSafe_ff;
    assign dataExchangeEn = dataExchangeEn_ff;
    assign processDataValid = dataValid_ff;
endmodule
`default_nettype wire

// ===== tb/status_led_asserts.sv
// Assertion checker for the status indicator block
`timescale 1ns/100ps
`default_nettype none
module status_led_asserts #(
    parameter int FLASH_CYC = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Inputs
    input wire logic [2:0] slaveState,
    input wire logic valueStable,
    input wire logic measRunning,
    input wire logic selfCalActive,
    input wire logic selfTestActive,
    input wire logic filterInit,
    input wire logic diffOutOfRange,
    input wire logic refOutOfRange,
    // Outputs
    input wire logic run_led,
    input wire logic stable_led,
    input wire logic measuring_led,
    input wire logic self_cal_led,
    input wire logic self_test_led,
    input wire logic diff_range_error_led,
    input wire logic ref_range_error_led,
    input wire logic outputsSafe,
    input wire logic dataExchangeEn,
    input wire logic processDataValid
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    int hiCnt_ff;
    logic preOk_ff;
    // A lit run only counts once it began from a dark phase shown under the flashing state
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            hiCnt_ff <= 0;
            preOk_ff <= 1'b0;
        end else begin
            hiCnt_ff <= run_led ? hiCnt_ff + 1 : 0;
            preOk_ff <= (slaveState != 3'h2) ? 1'b0 : ((!run_led && $past(slaveState) == 3'h2) ? 1'b1 : preOk_ff);
        end
    end
    a_run_dark_init: assert property ($past(resetn) && $past(slaveState) == 3'h1 |-> !run_led)
        else $error("run indicator lit in init");
    a_run_steady_op: assert property ($past(resetn) && $past(slaveState) == 3'h0 |-> run_led)
        else $error("run indicator dark in operational");
    a_flash_length: assert property ($fell(run_led) && preOk_ff |-> hiCnt_ff == FLASH_CYC)
        else $error("flash lit phase has wrong length");
    a_safe_state: assert property ($past(resetn) |-> outputsSafe == ($past(slaveState) != 3'h0) && dataExchangeEn != outputsSafe)
        else $error("safe state or data exchange wrong");
    a_stable_copy: assert property ($past(resetn) |-> stable_led == $past(valueStable))
        else $error("stability indicator wrong");
    a_meas_gate: assert property ($past(resetn) |-> measuring_led == $past(measRunning && !(selfCalActive || selfTestActive || filterInit)))
        else $error("measuring indicator wrong");
    a_cal_test_copy: assert property ($past(resetn) |-> self_cal_led == $past(selfCalActive) && self_test_led == $past(selfTestActive))
        else $error("calibration or test indicator wrong");
    a_data_invalid: assert property (self_cal_led || self_test_led |-> !processDataValid && !measuring_led)
        else $error("process data valid during calibration or test");
    a_range_copy: assert property ($past(resetn) |-> {diff_range_error_led, ref_range_error_led} == $past({diffOutOfRange, refOutOfRange}))
        else $error("range error indicator wrong");
endmodule
bind bridge_input_status_leds status_led_asserts #(.FLASH_CYC(FLASH_CYC)) i_chk (.*);
`default_nettype wire

// ===== tb/led_observer.sv
// Operator model timing the lit and dark runs of one indicator
`timescale 1ns/100ps
`default_nettype none
module led_observer (
    // Clock
    input wire logic core_clk,
    // Watched indicator
    input wire logic led,
    // Last complete lit and dark run lengths in cycles
    output var int hiLen,
    output var int loLen
);
    int runLen_ff = 0;
    logic prevLed_ff = 1'b0;
    always @(posedge core_clk) begin
        if (led !== prevLed_ff) begin
            if (prevLed_ff) begin
                hiLen <= runLen_ff;
            end else begin
                loLen <= runLen_ff;
            end
            runLen_ff <= 1;
        end else begin
            runLen_ff <= runLen_ff + 1;
        end
        prevLed_ff <= led;
    end
endmodule
`default_nettype wire

// ===== tb/bridge_input_status_leds_tb.sv
// Self-checking bench for the status indicator block
`timescale 1ns/100ps
`default_nettype none
module bridge_input_status_leds_tb;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] slaveState = 3'h1;
    logic valueStable = 1'b0, measRunning = 1'b0, selfCalActive = 1'b0, selfTestActive = 1'b0;
    logic filterInit = 1'b0, diffOutOfRange = 1'b0, refOutOfRange = 1'b0;
    logic run_led, stable_led, measuring_led, self_cal_led, self_test_led, diff_range_error_led, ref_range_error_led;
    logic outputsSafe, dataExchangeEn, processDataValid;
    int hiLen, loLen, fail_count = 0, n_checks = 0;
    logic [19:0] notes[$];
    logic [19:0] note;
    logic [23:0] pat[3] = '{24'h080802, 24'h240404, 24'h020203};
    wire [9:0] outs = {run_led, stable_led, measuring_led, self_cal_led, self_test_led, diff_range_error_led,
        ref_range_error_led, outputsSafe, dataExchangeEn, processDataValid};
    always #20 core_clk = ~core_clk;
    bridge_input_status_leds #(.FLASH_CYC(8), .SINGLE_ON_CYC(4), .SINGLE_PERIOD_CYC(40), .FLICKER_CYC(2)) i_dut (.*);
    led_observer i_obs (.core_clk(core_clk), .led(run_led), .hiLen(hiLen), .loLen(loLen));
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] expv);
        n_checks++;
        if (seen !== expv) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Run pattern is only predictable as a level in operational, init and unknown codes
    task automatic drive(input logic [2:0] st, input logic [6:0] b);
        logic m;
        @(negedge core_clk);
        slaveState = st;
        {valueStable, measRunning, selfCalActive, selfTestActive, filterInit, diffOutOfRange, refOutOfRange} = b;
        m = b[5] && !(b[4] || b[3] || b[2]);
        notes.push_back({st < 3'h2 || st > 3'h4, 9'h1ff, st == 3'h0, b[6], m, b[4], b[3], b[1], b[0], st != 3'h0,
            st == 3'h0, m});
    endtask
    task automatic reset_for(input int n);
        resetn = 1'b0;
        repeat (n) @(negedge core_clk);
        check("reset outputs", outs, 10'h004);
        resetn = 1'b1;
    endtask
    // Sample after the edge so its updates have landed
    always @(posedge core_clk) begin
        #1;
        if (notes.size() > 0) begin
            note = notes.pop_front();
            check("outputs", outs & note[19:10], note[9:0]);
        end
    end
    initial begin
        void'($urandom(99));
        reset_for(3);
        repeat (300) drive(3'($urandom_range(7)), 7'($urandom));
        @(negedge core_clk);
        reset_for(2);
        repeat (300) drive(3'($urandom_range(7)), 7'($urandom));
        foreach (pat[i]) begin
            repeat (130) drive(pat[i][2:0], 7'($urandom));
            check("lit run", 10'(hiLen), {2'h0, pat[i][15:8]});
            check("dark run", 10'(loLen), {2'h0, pat[i][23:16]});
        end
        for (int k = 0; k < 4 && notes.size() > 0; k++) @(negedge core_clk);
        if (notes.size() > 0) fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
